// *** efrb_top.sv ***
// bank of event flag registers with reset qualifiers
`timescale 1ns/1ps
`include "efrb_regs.svh"
module efrb_top
  import efrb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire efrb_req_t req,
  input wire efrb_rst_t rst_ev,
  input wire logic [`EFRB_NUM_REGS*16-1:0] set_ev,
  input wire logic si_wr_mask,
  input wire logic si_wr_mode,
  input wire logic pc_wr,
  input wire logic [7:0] pc_wdata,
  output efrb_word_t rdata_q,
  output logic rd_valid_q,
  output efrb_word_t serial_interface_mask_reg,
  output efrb_word_t serial_interface_mode_reg,
  output logic [7:0] port_c_data_reg,
  output logic [`EFRB_NUM_REGS*16-1:0] flags
);
  logic [`EFRB_NUM_REGS-1:0] init;
  logic [3:0] unit_rst;
  logic sys_clear;
  efrb_word_t serial_interface_mask_reg_q;
  efrb_word_t serial_interface_mode_reg_q;
  logic [7:0] port_c_data_reg_q;
  assign sys_clear = rst_ev.sys_reset | rst_ev.cpu_reset_instr;
  assign unit_rst = rst_ev.unit_soft_rst;
  genvar g;
  generate
    for (g = 0; g < `EFRB_NUM_REGS; g++) begin : gen_flag
      if (g == `EFRB_IDX_DMA) begin : g_dma
        assign init[g] = sys_clear | unit_rst[`EFRB_UNIT_DMA];
      end else if (g == `EFRB_IDX_TMR1) begin : g_t1
        assign init[g] = sys_clear | unit_rst[`EFRB_UNIT_TMR1];
      end else if (g == `EFRB_IDX_TMR2) begin : g_t2
        assign init[g] = sys_clear | unit_rst[`EFRB_UNIT_TMR2];
      end else if (g >= `EFRB_IDX_SER1 && g <= `EFRB_IDX_SER3) begin : g_cp
        assign init[g] = sys_clear | unit_rst[`EFRB_UNIT_CP];
      end else begin : g_oth
        assign init[g] = sys_clear;
      end
      efrb_flag_reg u_reg (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .init(init[g]),
        .clr_wr(req.wr && req.idx == efrb_idx_t'(g)),
        .clr_data(req.wdata),
        .set_ev(set_ev[g*16 +: 16]),
        .flags_q(flags[g*16 +: 16])
      );
    end
  endgenerate
  // serial mask and mode, system reset only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_interface_mask_reg_q <= `EFRB_SERIAL_INTERFACE_MASK_REG_RST;
      serial_interface_mode_reg_q <= `EFRB_SERIAL_INTERFACE_MODE_REG_RST;
    end else if (ce) begin
      if (rst_ev.sys_reset) begin
        serial_interface_mask_reg_q <= `EFRB_SERIAL_INTERFACE_MASK_REG_RST;
        serial_interface_mode_reg_q <= `EFRB_SERIAL_INTERFACE_MODE_REG_RST;
      end else begin
        if (si_wr_mask) begin
          serial_interface_mask_reg_q <= req.wdata;
        end
        if (si_wr_mode) begin
          serial_interface_mode_reg_q <= req.wdata;
        end
      end
    end
  end
  // port c latches hold without reset
  always_ff @(posedge clk) begin
    if (ce && pc_wr) begin
      port_c_data_reg_q <= pc_wdata;
    end
  end
  // read path, no effect on flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= `EFRB_FLAG_RST;
      rd_valid_q <= 1'b0;
    end else if (ce) begin
      rd_valid_q <= req.rd;
      if (req.rd && req.idx < efrb_idx_t'(`EFRB_NUM_REGS)) begin
        rdata_q <= flags[req.idx*16 +: 16];
      end else if (req.rd) begin
        rdata_q <= `EFRB_FLAG_RST;
      end
    end
  end
  assign serial_interface_mask_reg = serial_interface_mask_reg_q;
  assign serial_interface_mode_reg = serial_interface_mode_reg_q;
  assign port_c_data_reg = port_c_data_reg_q;
  // a read request taken this cycle
  sequence s_read_req;
    ce && req.rd;
  endsequence
  // the registered answer of a read
  sequence s_read_ans;
    rd_valid_q;
  endsequence
  a_sys_clear: assert property (@(posedge clk) disable iff (!rst_n)
    ce && sys_clear |=> flags == '0)
    else $error("flags not cleared");
  // dma soft reset clears dma flags
  a_unit_clear: assert property (@(posedge clk) disable iff (!rst_n)
    ce && unit_rst[`EFRB_UNIT_DMA] |=> flags[15:0] == '0)
    else $error("dma flags kept");
  a_tmr1_clear: assert property (@(posedge clk) disable iff (!rst_n)
    ce && unit_rst[`EFRB_UNIT_TMR1] |=> flags[63:48] == '0)
    else $error("timer one flags kept");
  a_tmr2_clear: assert property (@(posedge clk) disable iff (!rst_n)
    ce && unit_rst[`EFRB_UNIT_TMR2] |=> flags[79:64] == '0)
    else $error("timer two flags kept");
  a_cp_clear: assert property (@(posedge clk) disable iff (!rst_n)
    ce && unit_rst[`EFRB_UNIT_CP] |=> flags[127:80] == '0)
    else $error("serial flags kept");
  a_mask_keeps: assert property (@(posedge clk) disable iff (!rst_n)
    ce && rst_ev.cpu_reset_instr && !rst_ev.sys_reset && !si_wr_mask
    |=> $stable(serial_interface_mask_reg_q))
    else $error("mask changed");
  a_mask_init: assert property (@(posedge clk) disable iff (!rst_n)
    ce && rst_ev.sys_reset |=> serial_interface_mask_reg_q == `EFRB_SERIAL_INTERFACE_MASK_REG_RST)
    else $error("mask not reset");
  a_mode_keeps: assert property (@(posedge clk) disable iff (!rst_n)
    ce && rst_ev.cpu_reset_instr && !rst_ev.sys_reset && !si_wr_mode
    |=> $stable(serial_interface_mode_reg_q))
    else $error("mode changed");
  a_mode_init: assert property (@(posedge clk) disable iff (!rst_n)
    ce && rst_ev.sys_reset |=> serial_interface_mode_reg_q == `EFRB_SERIAL_INTERFACE_MODE_REG_RST)
    else $error("mode not reset");
  a_port_write: assert property (@(posedge clk) disable iff (!rst_n)
    ce && pc_wr |=> port_c_data_reg == $past(pc_wdata))
    else $error("port c write lost");
  a_read_data: assert property (@(posedge clk) disable iff (!rst_n)
    ce && req.rd && req.idx == 4'h0 |=> rd_valid_q && rdata_q == $past(flags[15:0]))
    else $error("bad read data");
  a_rd_valid: assert property (@(posedge clk) disable iff (!rst_n)
    s_read_req |=> s_read_ans)
    else $error("read not answered");
  a_rd_idle: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !req.rd |=> !rd_valid_q)
    else $error("spurious read answer");
  a_rd_unmapped: assert property (@(posedge clk) disable iff (!rst_n)
    ce && req.rd && req.idx >= efrb_idx_t'(`EFRB_NUM_REGS) |=> rdata_q == '0)
    else $error("unmapped read not zero");
  // a lone read leaves flags alone
  a_rd_no_side: assert property (@(posedge clk) disable iff (!rst_n)
    ce && req.rd && !req.wr && !sys_clear && unit_rst == 4'h0 && set_ev == '0
    |=> flags == $past(flags))
    else $error("read changed flags");
  // clock enable low freezes flags and read path
  a_ce_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    !ce |=> $stable(flags) && $stable(rdata_q) && $stable(rd_valid_q))
    else $error("state moved while frozen");
  // clock enable low freezes serial registers
  a_ce_regs: assert property (@(posedge clk) disable iff (!rst_n)
    !ce |=> $stable(serial_interface_mask_reg_q) && $stable(serial_interface_mode_reg_q))
    else $error("serial regs moved while frozen");
  generate
    for (g = 0; g < `EFRB_NUM_REGS; g++) begin : gen_chk
      a_ev_sets: assert property (@(posedge clk) disable iff (!rst_n)
        ce && !init[g] |=> (flags[g*16 +: 16] & $past(set_ev[g*16 +: 16])) ==
        $past(set_ev[g*16 +: 16]))
        else $error("event bit not set");
      a_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        ce && !init[g] && !(req.wr && req.idx == efrb_idx_t'(g)) |=>
        (flags[g*16 +: 16] & $past(flags[g*16 +: 16])) == $past(flags[g*16 +: 16]))
        else $error("flag dropped by hardware");
      a_one_clear: assert property (@(posedge clk) disable iff (!rst_n)
        ce && !init[g] && req.wr && req.idx == efrb_idx_t'(g) |=>
        (flags[g*16 +: 16] & $past(req.wdata & ~set_ev[g*16 +: 16])) == '0)
        else $error("written one did not clear");
      a_zero_keep: assert property (@(posedge clk) disable iff (!rst_n)
        ce && !init[g] && req.wr && req.idx == efrb_idx_t'(g) |=>
        (flags[g*16 +: 16] & $past(flags[g*16 +: 16] & ~req.wdata)) ==
        $past(flags[g*16 +: 16] & ~req.wdata))
        else $error("written zero cleared a flag");
      a_init_clear: assert property (@(posedge clk) disable iff (!rst_n)
        ce && init[g] |=> flags[g*16 +: 16] == '0)
        else $error("init left flags set");
    end
  endgenerate
endmodule

// *** efrb_regs.svh ***
// constants for the event flag register bank
`ifndef EFRB_REGS_SVH
`define EFRB_REGS_SVH
`define EFRB_NUM_REGS 12
`define EFRB_IDX_DMA 4'h0
`define EFRB_IDX_IPEND 4'h1
`define EFRB_IDX_ISERV 4'h2
`define EFRB_IDX_TMR1 4'h3
`define EFRB_IDX_TMR2 4'h4
`define EFRB_IDX_SER1 4'h5
`define EFRB_IDX_SER2 4'h6
`define EFRB_IDX_SER3 4'h7
`define EFRB_IDX_CRW 4'h8
`define EFRB_IDX_CAW 4'h9
`define EFRB_IDX_CHE 4'ha
`define EFRB_IDX_UART 4'hb
`define EFRB_FLAG_RST 16'h0000
`define EFRB_SERIAL_INTERFACE_MASK_REG_RST 16'hffff
`define EFRB_SERIAL_INTERFACE_MODE_REG_RST 16'h0000
`define EFRB_UNIT_DMA 0
`define EFRB_UNIT_TMR1 1
`define EFRB_UNIT_TMR2 2
`define EFRB_UNIT_CP 3
`endif

// *** efrb_pkg.sv ***
// types for the event flag register bank
package efrb_pkg;
  typedef logic [15:0] efrb_word_t;
  typedef logic [3:0] efrb_idx_t;
  typedef struct packed {
    logic wr;
    logic rd;
    efrb_idx_t idx;
    efrb_word_t wdata;
  } efrb_req_t;
  typedef struct packed {
    logic sys_reset;
    logic cpu_reset_instr;
    logic [3:0] unit_soft_rst;
  } efrb_rst_t;
  typedef enum logic [1:0] {
    EFRB_RUN = 2'b00,
    EFRB_CLR = 2'b01
  } efrb_mode_t;
endpackage

// *** efrb_flag_reg.sv ***
// one write-one-to-clear event flag register
`timescale 1ns/1ps
module efrb_flag_reg
  import efrb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic init,
  input wire logic clr_wr,
  input wire efrb_word_t clr_data,
  input wire efrb_word_t set_ev,
  output efrb_word_t flags_q
);
  `include "efrb_regs.svh"
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= `EFRB_FLAG_RST;
    end else if (ce) begin
      if (init) begin
        flags_q <= `EFRB_FLAG_RST;
      end else begin
        flags_q <= (flags_q & ~(clr_wr ? clr_data : `EFRB_FLAG_RST)) | set_ev;
      end
    end
  end
  // a new event is kept while ce is high and init is low
  a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !init && set_ev[0] |=> flags_q[0])
    else $error("event lost");
  // zero write keeps a set bit
  a_zero_keeps: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !init && flags_q[1] && !(clr_wr && clr_data[1]) |=> flags_q[1])
    else $error("flag dropped");
  a_one_clears: assert property (@(posedge clk) disable iff (!rst_n)
    ce && clr_wr && clr_data[2] && !set_ev[2] |=> !flags_q[2])
    else $error("flag not cleared");
endmodule

// *** efrb_sw_model.sv ***
// processor software model issuing bus accesses
`timescale 1ns/1ps
module efrb_sw_model
  import efrb_pkg::*;
(
  input wire logic clk,
  output efrb_req_t req
);
  initial req = '0;
  task automatic clr(input efrb_idx_t i, input efrb_word_t m);
    req = '{wr: 1'b1, rd: 1'b0, idx: i, wdata: m};
    @(posedge clk);
    req <= '0;
    #1;
  endtask
  task automatic rd(input efrb_idx_t i);
    req = '{wr: 1'b0, rd: 1'b1, idx: i, wdata: 16'h0000};
    @(posedge clk);
    req <= '0;
    #1;
  endtask
endmodule

// *** tb_efrb_top.sv ***
// testbench for the event flag register bank
`timescale 1ns/1ps
`include "efrb_regs.svh"
module tb_efrb_top;
  import efrb_pkg::*;
  typedef struct {efrb_idx_t i; efrb_word_t s; efrb_word_t m; bit same; efrb_word_t e;} efrb_row_t;
  logic clk = 0;
  logic rst_n = 0;
  efrb_req_t req;
  efrb_rst_t rst_ev = '0;
  logic [`EFRB_NUM_REGS*16-1:0] set_ev = '0;
  logic [`EFRB_NUM_REGS*16-1:0] flags;
  logic si_wr_mask = 0;
  logic si_wr_mode = 0;
  logic ce = 1;
  logic pc_wr = 0;
  logic rd_valid_q;
  logic [7:0] pc_wdata = 8'h00;
  logic [7:0] pc_q;
  efrb_word_t rdata_q, mask_q, mode_q;
  int error_cnt = 0;
  int n_tests = 0;
  efrb_row_t rows[4] = '{'{4'h0, 16'h00ff, 16'h000f, 0, 16'h00f0},
    '{4'h5, 16'ha5a5, 16'h0000, 0, 16'ha5a5}, '{4'hb, 16'hffff, 16'hffff, 0, 16'h0000},
    '{4'h3, 16'h0001, 16'h0001, 1, 16'h0001}};
  efrb_top dut(.clk(clk), .rst_n(rst_n), .ce(ce), .req(req), .rst_ev(rst_ev),
    .set_ev(set_ev), .si_wr_mask(si_wr_mask), .si_wr_mode(si_wr_mode), .pc_wr(pc_wr),
    .pc_wdata(pc_wdata), .rdata_q(rdata_q), .rd_valid_q(rd_valid_q),
    .serial_interface_mask_reg(mask_q), .serial_interface_mode_reg(mode_q),
    .port_c_data_reg(pc_q), .flags(flags));
  efrb_sw_model sw(.clk(clk), .req(req));
  always #5 clk = ~clk;
  task automatic chk(string n, efrb_word_t e, efrb_word_t g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic ev(int i, efrb_word_t s);
    set_ev[i*16+:16] = s;
    @(posedge clk);
    set_ev <= '0;
    #1;
  endtask
  task automatic pulse(efrb_rst_t r);
    rst_ev = r;
    @(posedge clk);
    rst_ev <= '0;
    #1;
  endtask
  task end_sim;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    end_sim;
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 rst_n = 1;
    chk("flags", 16'h0000, flags[15:0]);
    chk("mask", 16'hffff, mask_q);
    chk("mode", 16'h0000, mode_q);
    foreach (rows[k]) begin
      set_ev[rows[k].i*16+:16] = rows[k].s;
      if (rows[k].same) sw.clr(rows[k].i, rows[k].m);
      else @(posedge clk) #1;
      set_ev = '0;
      if (!rows[k].same) sw.clr(rows[k].i, rows[k].m);
      chk("flags", rows[k].e, flags[rows[k].i*16+:16]);
      sw.rd(rows[k].i);
      chk("rdata", rows[k].e, rdata_q);
      chk("rd_valid", 16'h0001, {15'h0000, rd_valid_q});
      chk("flags_after_rd", rows[k].e, flags[rows[k].i*16+:16]);
      sw.clr(rows[k].i, 16'hffff);
    end
    ev(1, 16'h0001);
    sw.rd(4'h1);
    ev(1, 16'h0002);
    sw.clr(4'h1, 16'h0001);
    chk("pending", 16'h0002, flags[31:16]);
    sw.rd(4'hc);
    chk("rdata_unmapped", 16'h0000, rdata_q);
    ev(3, 16'h0010);
    ev(4, 16'h0020);
    pulse(6'b000010);
    chk("tmr1", 16'h0000, flags[63:48]);
    chk("tmr2", 16'h0020, flags[79:64]);
    si_wr_mask = 1;
    si_wr_mode = 1;
    sw.clr(4'hf, 16'h1234);
    si_wr_mask = 0;
    si_wr_mode = 0;
    pc_wr = 1;
    pc_wdata = 8'h5a;
    @(posedge clk) #1 pc_wr = 0;
    chk("port_c", 16'h005a, {8'h00, pc_q});
    pulse(6'b010000);
    chk("tmr2", 16'h0000, flags[79:64]);
    chk("pending", 16'h0000, flags[31:16]);
    chk("mask", 16'h1234, mask_q);
    chk("mode", 16'h1234, mode_q);
    ev(2, 16'h8000);
    pulse(6'b100000);
    chk("iserv", 16'h0000, flags[47:32]);
    chk("mask", 16'hffff, mask_q);
    chk("mode", 16'h0000, mode_q);
    ce = 0;
    ev(0, 16'h0001);
    chk("frozen", 16'h0000, flags[15:0]);
    ce = 1;
    ev(5, 16'h0003);
    ev(0, 16'h0004);
    pulse(6'b001000);
    chk("serial1", 16'h0000, flags[95:80]);
    chk("dma", 16'h0004, flags[15:0]);
    pulse(6'b000001);
    chk("dma", 16'h0000, flags[15:0]);
    end_sim;
  end
endmodule
